// ===== design/pfm_consts.svh
// Address, field, reset, code and strap constants for the port pin function multiplexer.
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH

// Byte addresses of the two selector registers.
`define PFM_ADDR_P0H 32'hE002C004
`define PFM_ADDR_WIDE 32'hE002C014

// Reset value of the port 0 high selector: pins 27 to 30 start on code 01.
`define PFM_P0H_RESET 32'h15400000

// Valid selector codes, four bits per pin from pin 16 upward; bit k set means code k valid.
`define PFM_P0H_VALID 64'h0FFFF0333DBFFFF7

// Field positions inside the wide group selector.
`define PFM_WIDE_DEBUG 2
`define PFM_WIDE_TRACE 3
`define PFM_WIDE_BUS_LO 4
`define PFM_WIDE_ANA6 6
`define PFM_WIDE_ANA7 7
`define PFM_WIDE_WE 8

// Reset values of the fields that do not come from straps.
`define PFM_WIDE_ANA6_RESET 1'h1
`define PFM_WIDE_ANA7_RESET 1'h1
`define PFM_WIDE_WE_RESET 1'h0

// Bus field codes.
`define PFM_BUS_8 2'h0
`define PFM_BUS_16 2'h1
`define PFM_BUS_32 2'h2
`define PFM_BUS_NONE 2'h3

// Strap pin positions inside the wide pad vector (port 1 pins 26 and 20).
`define PFM_STRAP_RETURNED_TEST_CLOCK_BIT 26
`define PFM_STRAP_TSYNC_BIT 20

`endif

// ===== design/pfm_pkg.sv
// Types shared by the port pin function multiplexer.
package pfm_pkg;

  // Strap capture sequence after reset, Gray coded.
  typedef enum logic [1:0] {
    PFM_WAIT0 = 2'h0,
    PFM_WAIT1 = 2'h1,
    PFM_LOAD = 2'h3,
    PFM_RUN = 2'h2
  } pfm_state_e;

  // Whole state of the multiplexer, registered in one place.
  typedef struct packed {
    pfm_state_e st;
    logic [15:0] p0_s1;
    logic [15:0] p0_s2;
    logic [95:0] pw_s1;
    logic [95:0] pw_s2;
    logic [1:0] boot_s1;
    logic [1:0] boot_s2;
    logic [31:0] sel1;
    logic [8:2] sel2;
    logic [31:0] rd_data;
    logic [15:0] p0_out;
    logic [15:0] p0_oe_n;
    logic [15:0] p0_gin;
    logic [47:0] p0_fin;
    logic [95:0] pw_out;
    logic [95:0] pw_oe_n;
    logic [95:0] pw_gin;
    logic [95:0] pw_ain;
    logic ana6;
    logic ana7;
  } pfm_state_s;

endpackage : pfm_pkg

// ===== design/pfm_pin_mux.sv
// Pin function multiplexer for port 0 pins 16 to 31 and the wide pin groups.
`include "pfm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module pfm_pin_mux (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port: byte address, write data and one-cycle strobes.
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Boot straps; they seed the bus width field once after reset.
  input wire logic [1:0] boot_select_pins,
  // Port 0 pins 16 to 31: bit i of each vector belongs to pin 16 plus i.
  // Peripheral vectors hold three slots per pin, one per non-GPIO code.
  input wire logic [15:0] p0_pad_in,
  output logic [15:0] p0_pad_out,
  output logic [15:0] p0_pad_oe_n,
  input wire logic [15:0] p0_gpio_out,
  input wire logic [15:0] p0_gpio_direction_register,
  output logic [15:0] p0_gpio_in,
  input wire logic [47:0] p0_func_out,
  input wire logic [47:0] p0_func_oe,
  output logic [47:0] p0_func_in,
  // Port 1: debug and trace groups, memory chip select and output enable.
  input wire logic [31:0] p1_pad_in,
  output logic [31:0] p1_pad_out,
  output logic [31:0] p1_pad_oe_n,
  input wire logic [31:0] p1_gpio_out,
  input wire logic [31:0] p1_gpio_direction_register,
  output logic [31:0] p1_gpio_in,
  input wire logic [31:0] p1_alt_out,
  input wire logic [31:0] p1_alt_oe,
  output logic [31:0] p1_alt_in,
  // Port 2: the external memory data bus, widened by the bus field.
  input wire logic [31:0] p2_pad_in,
  output logic [31:0] p2_pad_out,
  output logic [31:0] p2_pad_oe_n,
  input wire logic [31:0] p2_gpio_out,
  input wire logic [31:0] p2_gpio_direction_register,
  output logic [31:0] p2_gpio_in,
  input wire logic [31:0] p2_alt_out,
  input wire logic [31:0] p2_alt_oe,
  output logic [31:0] p2_alt_in,
  // Port 3: byte lanes, write strobe and the two analog capable pins.
  input wire logic [31:0] p3_pad_in,
  output logic [31:0] p3_pad_out,
  output logic [31:0] p3_pad_oe_n,
  input wire logic [31:0] p3_gpio_out,
  input wire logic [31:0] p3_gpio_direction_register,
  output logic [31:0] p3_gpio_in,
  input wire logic [31:0] p3_alt_out,
  input wire logic [31:0] p3_alt_oe,
  output logic [31:0] p3_alt_in,
  // Analog flags tell the converter that its pin is free of digital use.
  output logic analog_input_six,
  output logic analog_input_seven
);

  import pfm_pkg::*;

  // Timing overview of the block.
  // A selector write lands on the edge that takes the strobe.
  // The pads switch one edge later, because every output is registered.
  // A pad level reaches its owner three edges after it changes on the pin:
  // two synchroniser stages and the registered routing stage.
  // Software must therefore allow a few cycles between a write and the
  // first use of a newly routed input.
  // The straps are read from the second synchroniser stage only, so a
  // strap that moves near the release of reset cannot leave a half value.
  // A write that arrives in the strap load cycle is dropped on purpose:
  // letting it win would make the reset state depend on software timing.
  // Reserved codes release the pad and keep every function idle; this
  // costs nothing and keeps a wrong setting from fighting an outside driver.
  // Direction of a peripheral pin comes from the peripheral alone, so a
  // stale GPIO direction bit can never turn a receive pin into an output.
  // Analog mode hides the pin from both digital users and releases the pad,
  // so the converter sees the outside level without a digital load on it.

  // Current and next state of the whole block.
  pfm_state_s s_r;
  pfm_state_s s_nxt;

  // Table of legal selector codes for port 0 pins 16 to 31.
  localparam logic [63:0] P0_VALID = `PFM_P0H_VALID;

  // Drive of one pad: returns output level and drive enable, active high.
  // A pad that neither GPIO nor a peripheral owns is left undriven.
  // A peripheral always wins over GPIO, so a pin has one driver at most.
  // The same function serves both the port 0 and the wide pin loops.
  function automatic logic [1:0] pfm_route(
    input logic gpio_sel,
    input logic alt_sel,
    input logic gpio_o,
    input logic gpio_dir,
    input logic alt_o,
    input logic alt_en
  );
    logic [1:0] r;
    r = 2'h0;
    if (alt_sel) begin
      r = {alt_o, alt_en};
    end else if (gpio_sel) begin
      r = {gpio_o, gpio_dir};
    end
    return r;
  endfunction : pfm_route

  // Wide groups are handled as one 96-bit vector: port 1 low, port 3 high.
  logic [95:0] w_gpio_out;
  logic [95:0] w_gpio_dir;
  logic [95:0] w_alt_out;
  logic [95:0] w_alt_oe;

  // Gathering of the wide group inputs.
  assign w_gpio_out = {p3_gpio_out, p2_gpio_out, p1_gpio_out};
  assign w_gpio_dir = {p3_gpio_direction_register, p2_gpio_direction_register,
                       p1_gpio_direction_register};
  assign w_alt_out = {p3_alt_out, p2_alt_out, p1_alt_out};
  assign w_alt_oe = {p3_alt_oe, p2_alt_oe, p1_alt_oe};

  // All next-state logic: synchronisers, strap capture, registers and routing.
  always_comb begin
    logic [1:0] code;
    logic [1:0] idx;
    logic ok;
    logic gs;
    logic as;
    logic [1:0] r;
    logic [1:0] bus;
    logic mem_lo;
    logic mem_mid;
    logic mem_hi;
    logic [95:0] wsel;
    logic [95:0] wana;
    code = 2'h0;
    idx = 2'h0;
    ok = 1'b0;
    gs = 1'b0;
    as = 1'b0;
    r = 2'h0;
    // Every local starts from a constant so no path leaves a latch behind.
    bus = 2'h0;
    mem_lo = 1'b0;
    mem_mid = 1'b0;
    mem_hi = 1'b0;
    wsel = 96'h0;
    wana = 96'h0;
    s_nxt = s_r;

    // Pad and strap inputs come from outside and pass two flops first.
    s_nxt.p0_s1 = p0_pad_in;
    s_nxt.p0_s2 = s_r.p0_s1;
    s_nxt.pw_s1 = {p3_pad_in, p2_pad_in, p1_pad_in};
    s_nxt.pw_s2 = s_r.pw_s1;
    s_nxt.boot_s1 = boot_select_pins;
    s_nxt.boot_s2 = s_r.boot_s1;

    // Straps are caught once, two cycles after release, when the second stage holds them.
    case (s_r.st)
      PFM_WAIT0: begin
        // First stage of the synchronisers is filling.
        s_nxt.st = PFM_WAIT1;
      end
      PFM_WAIT1: begin
        // Second stage is filling; the strap levels are not yet safe.
        s_nxt.st = PFM_LOAD;
      end
      PFM_LOAD: begin
        s_nxt.sel2[`PFM_WIDE_DEBUG] = s_r.pw_s2[`PFM_STRAP_RETURNED_TEST_CLOCK_BIT];
        s_nxt.sel2[`PFM_WIDE_TRACE] = s_r.pw_s2[`PFM_STRAP_TSYNC_BIT];
        s_nxt.sel2[`PFM_WIDE_BUS_LO +: 2] = s_r.boot_s2;
        s_nxt.st = PFM_RUN;
      end
      PFM_RUN: begin
        // Straps are ignored from here on; only software changes the fields.
        s_nxt.st = PFM_RUN;
      end
      default: begin
        // An illegal state restarts the capture rather than running unseeded.
        s_nxt.st = PFM_WAIT0;
      end
    endcase

    // Register writes; a write in the load cycle is dropped, to either register.
    if (reg_wr && s_r.st != PFM_LOAD) begin
      if (reg_addr == `PFM_ADDR_P0H) begin
        s_nxt.sel1 = reg_wdata;
      end else if (reg_addr == `PFM_ADDR_WIDE) begin
        s_nxt.sel2 = reg_wdata[8:2];
      end
    end

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    s_nxt.rd_data = 32'h00000000;
    if (reg_rd) begin
      if (reg_addr == `PFM_ADDR_P0H) begin
        s_nxt.rd_data = s_r.sel1;
      end else if (reg_addr == `PFM_ADDR_WIDE) begin
        s_nxt.rd_data = {23'h000000, s_r.sel2, 2'h0};
      end
    end

    // Port 0 high pins: the two-bit code picks GPIO or one of three slots.
    // Reserved codes leave the pin undriven and every function idle, the safest answer
    // to a setting that software must not make.
    s_nxt.p0_fin = 48'h000000000000;
    for (int i = 0; i < 16; i++) begin
      code = s_r.sel1[2*i +: 2];
      ok = P0_VALID[4*i + code];
      gs = ok && (code == 2'h0);
      as = ok && (code != 2'h0);
      idx = (code == 2'h0) ? 2'h0 : code - 2'h1;
      r = pfm_route(gs, as, p0_gpio_out[i], p0_gpio_direction_register[i],
                    p0_func_out[3*i + idx], p0_func_oe[3*i + idx]);
      s_nxt.p0_out[i] = r[1];
      s_nxt.p0_oe_n[i] = ~r[0];
      s_nxt.p0_gin[i] = gs & s_r.p0_s2[i];
      s_nxt.p0_fin[3*i + idx] = as & s_r.p0_s2[i];
    end

    // Bus width decode for the memory interface pins.
    bus = s_r.sel2[`PFM_WIDE_BUS_LO +: 2];
    mem_lo = (bus != `PFM_BUS_NONE);
    mem_mid = (bus == `PFM_BUS_16) || (bus == `PFM_BUS_32);
    mem_hi = (bus == `PFM_BUS_32);

    // Peripheral ownership of each wide pin.
    wsel = 96'h0;
    wsel[31:26] = {6{s_r.sel2[`PFM_WIDE_DEBUG]}};
    wsel[25:16] = {10{s_r.sel2[`PFM_WIDE_TRACE]}};
    wsel[1:0] = {2{mem_lo}};
    wsel[39:32] = {8{mem_lo}};
    wsel[47:40] = {8{mem_mid}};
    wsel[63:48] = {16{mem_hi}};
    wsel[95] = mem_lo;
    wsel[94] = mem_mid;
    wsel[93] = mem_hi;
    wsel[92] = mem_hi;
    wsel[91] = s_r.sel2[`PFM_WIDE_WE];

    // Analog use of port 3 pins 29 and 28 applies only below full bus width.
    wana = 96'h0;
    wana[93] = ~mem_hi & s_r.sel2[`PFM_WIDE_ANA6];
    wana[92] = ~mem_hi & s_r.sel2[`PFM_WIDE_ANA7];
    s_nxt.ana6 = wana[93];
    s_nxt.ana7 = wana[92];

    // Wide pins: analog mode releases the pad and hides it from both digital users.
    // A pin that is neither owned nor analog falls back to GPIO.
    for (int j = 0; j < 96; j++) begin
      gs = ~wsel[j] & ~wana[j];
      as = wsel[j];
      r = pfm_route(gs, as, w_gpio_out[j], w_gpio_dir[j], w_alt_out[j], w_alt_oe[j]);
      s_nxt.pw_out[j] = r[1];
      s_nxt.pw_oe_n[j] = ~r[0];
      s_nxt.pw_gin[j] = gs & s_r.pw_s2[j];
      s_nxt.pw_ain[j] = as & s_r.pw_s2[j];
    end
  end

  // The single state register; reset loads constants only, straps come later.
  // Pads are released only until the first edge; after it the reset selector values,
  // with the bus field on the 8-bit code, choose owners before the straps load.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.st <= PFM_WAIT0;
      s_r.sel1 <= `PFM_P0H_RESET;
      s_r.sel2[`PFM_WIDE_ANA6] <= `PFM_WIDE_ANA6_RESET;
      s_r.sel2[`PFM_WIDE_ANA7] <= `PFM_WIDE_ANA7_RESET;
      s_r.sel2[`PFM_WIDE_WE] <= `PFM_WIDE_WE_RESET;
      s_r.p0_oe_n <= 16'hFFFF;
      s_r.pw_oe_n <= {96{1'b1}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output is a bit of the state register.
  // Read data stand one cycle after the strobe and are zero otherwise.
  assign reg_rdata = s_r.rd_data;
  // Port 0 pad drive and the levels handed to GPIO and peripherals.
  assign p0_pad_out = s_r.p0_out;
  assign p0_pad_oe_n = s_r.p0_oe_n;
  assign p0_gpio_in = s_r.p0_gin;
  assign p0_func_in = s_r.p0_fin;
  // The wide vector is split back into its three ports, port 1 lowest.
  assign p1_pad_out = s_r.pw_out[31:0];
  assign p2_pad_out = s_r.pw_out[63:32];
  assign p3_pad_out = s_r.pw_out[95:64];
  assign p1_pad_oe_n = s_r.pw_oe_n[31:0];
  assign p2_pad_oe_n = s_r.pw_oe_n[63:32];
  assign p3_pad_oe_n = s_r.pw_oe_n[95:64];
  // Inputs of functions that do not own a pin stay low.
  assign p1_gpio_in = s_r.pw_gin[31:0];
  assign p2_gpio_in = s_r.pw_gin[63:32];
  assign p3_gpio_in = s_r.pw_gin[95:64];
  assign p1_alt_in = s_r.pw_ain[31:0];
  assign p2_alt_in = s_r.pw_ain[63:32];
  assign p3_alt_in = s_r.pw_ain[95:64];
  // Analog flags are low whenever the full bus width claims the pins.
  assign analog_input_six = s_r.ana6;
  assign analog_input_seven = s_r.ana7;

endmodule : pfm_pin_mux
`default_nettype wire

// ===== verification/pfm_pin_mux_assertions.sv
// Port relation checker for the pin function multiplexer.
`include "pfm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module pfm_pin_mux_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] p0_gpio_in,
  input wire logic [47:0] p0_func_in,
  input wire logic [31:0] p1_gpio_in,
  input wire logic [31:0] p1_alt_in,
  input wire logic [31:0] p3_pad_oe_n,
  input wire logic [31:0] p3_gpio_in,
  input wire logic [31:0] p3_alt_in,
  input wire logic analog_input_six,
  input wire logic analog_input_seven
);
  logic [15:0] p0_bad; // Set for a pin that reaches more than one function.
  // Flags each port 0 pin whose level goes to GPIO and a peripheral at once.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      p0_bad[i] = !$onehot0({p0_gpio_in[i], p0_func_in[3*i+:3]});
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence p0h_wr_s; reg_wr && reg_addr == `PFM_ADDR_P0H; endsequence
  sequence p0h_rd_s; reg_rd && reg_addr == `PFM_ADDR_P0H; endsequence
  rd_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside a read");
  p0h_store_a: assert property (
    p0h_wr_s ##1 p0h_rd_s |=> reg_rdata == $past(reg_wdata, 2)) else $error("selector lost");
  unmapped_rd_a: assert property (
    $past(reg_rd) && !($past(reg_addr) inside {`PFM_ADDR_P0H, `PFM_ADDR_WIDE})
    |-> reg_rdata == 32'h0) else $error("unmapped read returned data");
  wide_rsvd_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `PFM_ADDR_WIDE
    |-> reg_rdata[1:0] == 2'h0) else $error("reserved selector bits read set");
  p0_single_a: assert property (
    p0_bad == 16'h0) else $error("port 0 pin reaches two functions");
  p1_single_a: assert property (
    (p1_gpio_in & p1_alt_in) == 32'h0) else $error("port 1 pin reaches two functions");
  p3_single_a: assert property (
    (p3_gpio_in & p3_alt_in) == 32'h0) else $error("port 3 pin reaches two functions");
  analog_free_a: assert property (
    (analog_input_six -> p3_pad_oe_n[29] && !p3_gpio_in[29])
    && (analog_input_seven -> p3_pad_oe_n[28] && !p3_gpio_in[28]))
    else $error("analog pin still driven or read");
endmodule : pfm_pin_mux_chk
`default_nettype wire

// ===== verification/pfm_far_side.sv
// Peripheral side and package pads of port 0 pins 16 to 31.
`timescale 1ns/1ns
`default_nettype none
module pfm_far_side (
  input wire logic ref_clk,
  input wire logic [15:0] p0_pad_out,
  input wire logic [15:0] p0_pad_oe_n,
  input wire logic [15:0] ext_level,
  output logic [15:0] p0_pad_in,
  output logic [47:0] p0_func_out,
  output logic [47:0] p0_func_oe
);
  logic tx_bit_r = 1'b0; // Transmit level; it toggles so a stale pad shows up.
  // The transmitter changes its level every cycle.
  always_ff @(posedge ref_clk) begin
    tx_bit_r <= !tx_bit_r;
  end
  // A pad shows the device level while driven, else the outside driver.
  assign p0_pad_in = (p0_pad_out & ~p0_pad_oe_n) | (ext_level & p0_pad_oe_n);
  assign p0_func_out = {48{tx_bit_r}};
  // Only the pin 24 transmit slot asks to drive; receive slots stay inputs.
  assign p0_func_oe = 48'h000001000000;
endmodule : pfm_far_side
`default_nettype wire

// ===== verification/tb_pfm_pin_mux.sv
// Self-checking testbench for the pin function multiplexer.
`include "pfm_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_pfm_pin_mux;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
  logic [1:0] boot = 2'h3; // Boot straps select no external bus.
  logic [15:0] p0_in, p0_out, p0_oen, p0_gin, p0_go = 16'h0, p0_dir = 16'h0, ext = 16'h0;
  logic [47:0] fo, fe, fi;
  logic [31:0] w_in = 32'h04000000; // Debug strap pad high, trace strap low.
  logic [31:0] wg = 32'h0, wa = 32'hFFFFFFFF, p1_oen, p2_oen, p3_oen, p3_out;
  logic a6, a7;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  // Columns: selector, gpio, alternate, port 1, 2, 3 drive enables, analog, port 3 level.
  logic [31:0] tbl [5][8] = '{
    '{32'h1C, 32'h0, '1, 32'h0000FFFC, 32'hFFFF0000, 32'h3FFFFFFF, 32'h0, 32'hC0000000},
    '{32'h1E0, 32'h0, '1, 32'hFFFFFFFC, 32'h0, 32'h07FFFFFF, 32'h0, 32'hF8000000},
    '{32'hF0, 32'h0, '1, '1, '1, '1, 32'h3, 32'h0},
    '{32'h0, 32'h0, '1, 32'hFFFFFFFC, 32'hFFFFFF00, 32'h7FFFFFFF, 32'h0, 32'h80000000},
    '{32'hF0, '1, 32'h0, 32'h0, 32'h0, 32'h30000000, 32'h3, 32'hCFFFFFFF}};
  pfm_pin_mux i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .boot_select_pins(boot),
    .p0_pad_in(p0_in), .p0_pad_out(p0_out), .p0_pad_oe_n(p0_oen), .p0_gpio_out(p0_go),
    .p0_gpio_direction_register(p0_dir), .p0_gpio_in(p0_gin), .p0_func_out(fo),
    .p0_func_oe(fe), .p0_func_in(fi), .p1_pad_in(w_in), .p1_pad_out(), .p1_pad_oe_n(p1_oen),
    .p1_gpio_out(wg), .p1_gpio_direction_register(wg), .p1_gpio_in(), .p1_alt_out(wa),
    .p1_alt_oe(wa), .p1_alt_in(), .p2_pad_in(w_in), .p2_pad_out(), .p2_pad_oe_n(p2_oen),
    .p2_gpio_out(wg), .p2_gpio_direction_register(wg), .p2_gpio_in(), .p2_alt_out(wa),
    .p2_alt_oe(wa), .p2_alt_in(), .p3_pad_in(w_in), .p3_pad_out(p3_out), .p3_pad_oe_n(p3_oen),
    .p3_gpio_out(wg), .p3_gpio_direction_register(wg), .p3_gpio_in(), .p3_alt_out(wa),
    .p3_alt_oe(wa), .p3_alt_in(), .analog_input_six(a6), .analog_input_seven(a7));
  pfm_far_side i_far (.ref_clk(ref_clk), .p0_pad_out(p0_out), .p0_pad_oe_n(p0_oen),
    .ext_level(ext), .p0_pad_in(p0_in), .p0_func_out(fo), .p0_func_oe(fe));
  always #5 ref_clk = ~ref_clk;
  // Cuts a hung run short well after the sequence should have ended.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      miscompares++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so it is sampled there.
  task rd(input logic [31:0] a, input logic [31:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask : rd
  task reset_values();
    rd(`PFM_ADDR_P0H, 32'h15400000);
    rd(`PFM_ADDR_WIDE, 32'hF4);
    rd(32'hE002C008, 32'h0);
  endtask : reset_values
  task p0_gpio_route();
    p0_go <= 16'h0100;
    p0_dir <= 16'h0180;
    ext <= 16'h0280;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("p0_oen", p0_oen, 16'hFE7F);
    chk("pin24 level", p0_out[8], 1'b1);
    chk("p0_gin", p0_gin, 16'h0300);
  endtask : p0_gpio_route
  // Pins 23 to 25 go to the CAN functions while direction bits stay set.
  task p0_can_route();
    wr(`PFM_ADDR_P0H, 32'h15454000);
    rd(`PFM_ADDR_P0H, 32'h15454000);
    repeat (4) @(posedge ref_clk);
    #1;
    chk("p0_oen", p0_oen, 16'hFEFF);
    chk("p0_gin", p0_gin, 16'h0);
    chk("can2 rx", fi[21], 1'b1);
    chk("can1 rx", fi[27], 1'b1);
    chk("can2 tx", p0_out[8], !i_far.tx_bit_r);
  endtask : p0_can_route
  task wide_modes();
    for (int r = 0; r < 5; r++) begin
      wg <= tbl[r][1];
      wa <= tbl[r][2];
      wr(`PFM_ADDR_WIDE, tbl[r][0] | 32'h3);
      rd(`PFM_ADDR_WIDE, tbl[r][0]);
      @(posedge ref_clk);
      #1;
      chk("p1_oen", p1_oen, tbl[r][3]);
      chk("p2_oen", p2_oen, tbl[r][4]);
      chk("p3_oen", p3_oen, tbl[r][5]);
      chk("analog", {30'h0, a6, a7}, tbl[r][6]);
      chk("p3_out", p3_out, tbl[r][7]);
    end
  endtask : wide_modes
  task end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset_values();
    p0_gpio_route();
    p0_can_route();
    wide_modes();
    end_of_test();
  end
endmodule : tb_pfm_pin_mux
bind pfm_pin_mux pfm_pin_mux_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .p0_gpio_in(p0_gpio_in), .p0_func_in(p0_func_in),
  .p1_gpio_in(p1_gpio_in), .p1_alt_in(p1_alt_in), .p3_pad_oe_n(p3_pad_oe_n),
  .p3_gpio_in(p3_gpio_in), .p3_alt_in(p3_alt_in), .analog_input_six(analog_input_six),
  .analog_input_seven(analog_input_seven));
`default_nettype wire
